/* core/pbc_bypass_regs.sv */
// Bypass control register bank with the datapath steering it drives
`include "pbc_defines.svh"

module pbc_bypass_regs
	import pbc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hw_rst_n,
	input wire logic sw_rst,
	input wire logic sticky_en,
	input pbc_mgmt_req_t mgmt_req,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	input wire pbc_speed_t speed,
	input wire logic [4:0] tx_sym_raw,
	input wire logic [4:0] tx_sym_coded,
	input wire logic tx_coded_delim,
	output logic [4:0] tx_sym_to_scr,
	input wire logic [4:0] rx_sym_aligned,
	input wire logic [4:0] rx_sym_decoded,
	output logic [4:0] rx_sym_out,
	input wire logic rx_frame_valid,
	output logic crs,
	output pbc_ctrl_t ctrl,
	input wire logic an_start,
	input wire logic adv_np,
	input wire logic base_page_done,
	input wire logic auto_np_done,
	input wire logic an_end,
	output logic np_sw_control,
	output logic np_auto_active,
	input wire logic transmit_test_clock,
	input wire logic gen_clk,
	output logic mac_ref_clock_pin,
	output logic general_clock_out_pin
);

	logic [15:0] bypass_control;
	logic [15:0] next_bypass;
	logic sw_rst_s;
	pbc_np_state_t np_state;
	pbc_np_state_t next_np_state;
	logic np_user_latched;
	logic is_100;
	logic scr_mode_ok;
	logic coder_byp_act;
	logic hw_rst_n_s;

	// Software reset arrives from another register block on this clock
	assign sw_rst_s = sw_rst;

	// Only writable bits can change; reserved bits stay zero
	always_comb
	begin
		next_bypass = bypass_control;
		if (mgmt_req.wr && mgmt_req.addr == `PBC_OFS_BYPASS)
			next_bypass = (mgmt_req.wdata & `PBC_WR_MASK);
		if (sw_rst_s)
		begin
			if (sticky_en)
				next_bypass = (`PBC_RESET_VAL & ~`PBC_STICKY_MASK) | (bypass_control & `PBC_STICKY_MASK);
			else
				next_bypass = `PBC_RESET_VAL;
		end
	end

	// Bypass register storage
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			bypass_control <= `PBC_RESET_VAL;
		else
			bypass_control <= next_bypass;
	end

	// Registered read data; reserved locations answer zero
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			mgmt_rdata <= 16'h0000;
			mgmt_rvalid <= 1'b0;
		end
		else
		begin
			mgmt_rvalid <= mgmt_req.rd;
			if (mgmt_req.rd && mgmt_req.addr == `PBC_OFS_BYPASS)
				mgmt_rdata <= bypass_control & `PBC_WR_MASK;
			else
				mgmt_rdata <= 16'h0000;
		end
	end

	// Mode qualification of the bypass bits
	assign is_100 = (speed == PBC_SPD_100);
	assign scr_mode_ok = is_100 || (speed == PBC_SPD_1000);
	assign coder_byp_act = bypass_control[`PBC_BIT_CODER_BYP] & is_100;

	// Steering outputs toward PCS and auto-negotiation
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			ctrl <= '0;
		else
		begin
			ctrl.coder_bypass <= coder_byp_act;
			ctrl.scr_bypass <= bypass_control[`PBC_BIT_SCR_BYP] & scr_mode_ok;
			ctrl.descr_bypass <= bypass_control[`PBC_BIT_DESCR_BYP] & scr_mode_ok;
			ctrl.no_pair_swap <= bypass_control[`PBC_BIT_NO_SWAP];
			ctrl.no_pol_fix <= bypass_control[`PBC_BIT_NO_POL];
			ctrl.use_adv_in_pd <= bypass_control[`PBC_BIT_PAR_DET];
		end
	end

	// Symbol path; raw symbols skip the coder so no delimiters get in
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			tx_sym_to_scr <= 5'h00;
			rx_sym_out <= 5'h00;
		end
		else
		begin
			tx_sym_to_scr <= coder_byp_act ? tx_sym_raw : tx_sym_coded;
			rx_sym_out <= coder_byp_act ? rx_sym_aligned : rx_sym_decoded;
		end
	end

	// Carrier sense follows frame detection in both coder modes
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			crs <= 1'b0;
		else
			crs <= rx_frame_valid;
	end

	// Next-page sequencing
	always_comb
	begin
		next_np_state = np_state;
		case (np_state)
			PBC_NP_IDLE:
				if (an_start)
					next_np_state = PBC_NP_BASE;
			PBC_NP_BASE:
				if (base_page_done)
					next_np_state = bypass_control[`PBC_BIT_NO_AUTO_NP] ? PBC_NP_USER : PBC_NP_AUTO;
			PBC_NP_AUTO:
				if (auto_np_done)
					next_np_state = np_user_latched ? PBC_NP_USER : PBC_NP_DONE;
			PBC_NP_USER:
				next_np_state = PBC_NP_USER;
			PBC_NP_DONE:
				next_np_state = PBC_NP_DONE;
			default:
				next_np_state = PBC_NP_IDLE;
		endcase
		if (an_end)
			next_np_state = PBC_NP_IDLE;
		if (an_start)
			next_np_state = PBC_NP_BASE;
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			np_state <= PBC_NP_IDLE;
		else
			np_state <= next_np_state;
	end

	// Advertised next-page bit is caught at restart, later edits are ignored
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			np_user_latched <= 1'b0;
		else if (an_start)
			np_user_latched <= adv_np;
	end

	// Software sees control only in the user state
	assign np_sw_control = (np_state == PBC_NP_USER);
	assign np_auto_active = (np_state == PBC_NP_AUTO);

	// Hardware reset is a pin: retimed here, so the clock gate reacts two cycles late
	pbc_sync2 #(.WIDTH(1)) u_hw_rst_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.d(hw_rst_n),
		.q(hw_rst_n_s)
	);

	// Clock pin drivers
	pbc_clk_out u_clk_out (
		.ref_clk(ref_clk),
		.hw_rst_n(hw_rst_n_s),
		.mac_en(bypass_control[`PBC_BIT_MAC_CLK_EN]),
		.test_sel(bypass_control[`PBC_BIT_TEST_CLK]),
		.test_clk(transmit_test_clock),
		.gen_clk(gen_clk),
		.mac_ref_clock_pin(mac_ref_clock_pin),
		.general_clock_out_pin(general_clock_out_pin)
	);

	// Assertions
	property p_rsvd_zero;
		@(posedge ref_clk) disable iff (rst)
		(mgmt_req.rd && mgmt_req.addr != `PBC_OFS_BYPASS) |=> (mgmt_rdata == 16'h0000);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero");

	property p_rsvd_bits;
		@(posedge ref_clk) disable iff (rst)
		(bypass_control & ~`PBC_WR_MASK) == 16'h0000;
	endproperty
	a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bit set");

	property p_coder_speed;
		@(posedge ref_clk) disable iff (rst)
		(speed != PBC_SPD_100) |=> !ctrl.coder_bypass;
	endproperty
	a_coder_speed: assert property (p_coder_speed) else $error("coder bypass outside 100");

	property p_scr_follow;
		@(posedge ref_clk) disable iff (rst)
		(bypass_control[`PBC_BIT_SCR_BYP] && speed == PBC_SPD_1000) |=> ctrl.scr_bypass;
	endproperty
	a_scr_follow: assert property (p_scr_follow) else $error("scrambler bypass not applied");

	property p_scr_10;
		@(posedge ref_clk) disable iff (rst)
		(speed == PBC_SPD_10) |=> (!ctrl.scr_bypass && !ctrl.descr_bypass);
	endproperty
	a_scr_10: assert property (p_scr_10) else $error("scrambler bypass at 10");

	property p_tx_raw;
		@(posedge ref_clk) disable iff (rst)
		coder_byp_act |=> (tx_sym_to_scr == $past(tx_sym_raw));
	endproperty
	a_tx_raw: assert property (p_tx_raw) else $error("raw symbol not passed");

	property p_crs;
		@(posedge ref_clk) disable iff (rst)
		rx_frame_valid |=> crs;
	endproperty
	a_crs: assert property (p_crs) else $error("carrier sense missing");

	property p_np_manual;
		@(posedge ref_clk) disable iff (rst)
		(np_state == PBC_NP_BASE && base_page_done && bypass_control[1] && !an_end && !an_start)
			|=> np_sw_control;
	endproperty
	a_np_manual: assert property (p_np_manual) else $error("no software control after base page");

	property p_sticky;
		@(posedge ref_clk) disable iff (rst)
		(sw_rst && sticky_en) |=> (bypass_control[3:0] == ($past(bypass_control[3:0]) & 4'hb));
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky bits lost");

	property p_no_delim;
		@(posedge ref_clk) disable iff (rst)
		(coder_byp_act && tx_coded_delim) |=> (tx_sym_to_scr == $past(tx_sym_raw));
	endproperty
	a_no_delim: assert property (p_no_delim) else $error("delimiter inserted in coder bypass");

	property p_rx_raw;
		@(posedge ref_clk) disable iff (rst)
		coder_byp_act |=> (rx_sym_out == $past(rx_sym_aligned));
	endproperty
	a_rx_raw: assert property (p_rx_raw) else $error("aligned symbol not passed");

	property p_rx_coded;
		@(posedge ref_clk) disable iff (rst)
		(speed != PBC_SPD_100) |=> (rx_sym_out == $past(rx_sym_decoded));
	endproperty
	a_rx_coded: assert property (p_rx_coded) else $error("decoder bypassed outside 100");

	property p_descr_follow;
		@(posedge ref_clk) disable iff (rst)
		(bypass_control[`PBC_BIT_DESCR_BYP] && speed == PBC_SPD_100) |=> ctrl.descr_bypass;
	endproperty
	a_descr_follow: assert property (p_descr_follow) else $error("descrambler bypass not applied");

	property p_swap;
		@(posedge ref_clk) disable iff (rst)
		bypass_control[`PBC_BIT_NO_SWAP] |=> ctrl.no_pair_swap;
	endproperty
	a_swap: assert property (p_swap) else $error("pair swap correction still on");

	property p_pol;
		@(posedge ref_clk) disable iff (rst)
		bypass_control[`PBC_BIT_NO_POL] |=> ctrl.no_pol_fix;
	endproperty
	a_pol: assert property (p_pol) else $error("polarity correction still on");

	property p_par_det;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> (ctrl.use_adv_in_pd == $past(bypass_control[`PBC_BIT_PAR_DET]));
	endproperty
	a_par_det: assert property (p_par_det) else $error("parallel detect control not followed");

	property p_rsvd_write;
		@(posedge ref_clk) disable iff (rst)
		(mgmt_req.wr && mgmt_req.addr != `PBC_OFS_BYPASS && !sw_rst) |=> $stable(bypass_control);
	endproperty
	a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write changed register");

	property p_wr_land;
		@(posedge ref_clk) disable iff (rst)
		(mgmt_req.wr && mgmt_req.addr == `PBC_OFS_BYPASS && !sw_rst)
			|=> (bypass_control == ($past(mgmt_req.wdata) & `PBC_WR_MASK));
	endproperty
	a_wr_land: assert property (p_wr_land) else $error("write did not land");

	property p_np_auto;
		@(posedge ref_clk) disable iff (rst)
		(np_state == PBC_NP_BASE && base_page_done && !bypass_control[`PBC_BIT_NO_AUTO_NP])
			&& !an_end && !an_start |=> np_auto_active;
	endproperty
	a_np_auto: assert property (p_np_auto) else $error("automatic next pages not started");

	property p_np_user;
		@(posedge ref_clk) disable iff (rst)
		(np_state == PBC_NP_AUTO && auto_np_done && np_user_latched)
			&& !an_end && !an_start |=> np_sw_control;
	endproperty
	a_np_user: assert property (p_np_user) else $error("no control for user next pages");

	property p_np_silent;
		@(posedge ref_clk) disable iff (rst)
		(np_state == PBC_NP_AUTO && auto_np_done && !np_user_latched)
			&& !an_end && !an_start |=> (np_state == PBC_NP_DONE && !np_sw_control);
	endproperty
	a_np_silent: assert property (p_np_silent) else $error("software notified in automatic exchange");

endmodule : pbc_bypass_regs

/* core/pbc_defines.svh */
// Register offsets, field positions, reset values and timing counts for the bypass control bank
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH

`define PBC_OFS_RSVD_A 5'h11
`define PBC_OFS_BYPASS 5'h12
`define PBC_OFS_RSVD_B 5'h13
`define PBC_OFS_RSVD_C 5'h14

`define PBC_BIT_CODER_BYP 14
`define PBC_BIT_SCR_BYP 13
`define PBC_BIT_DESCR_BYP 12
`define PBC_BIT_TEST_CLK 8
`define PBC_BIT_NO_SWAP 5
`define PBC_BIT_NO_POL 4
`define PBC_BIT_PAR_DET 3
`define PBC_BIT_NO_AUTO_NP 1
`define PBC_BIT_MAC_CLK_EN 0

`define PBC_WR_MASK 16'h713b
`define PBC_STICKY_MASK 16'h000b
`define PBC_RESET_VAL 16'h0009

`define PBC_MAC_CLK_MHZ 125
`define PBC_REF_CLK_MHZ 125
`define PBC_MAC_CLK_DIV (`PBC_REF_CLK_MHZ / `PBC_MAC_CLK_MHZ)

`endif

/* core/pbc_pkg.sv */
// Types shared by the bypass control bank and its helpers
package pbc_pkg;

	// Management access request from the serial management engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} pbc_mgmt_req_t;

	// Operating speed reported by the link logic
	typedef enum logic [1:0] {
		PBC_SPD_10 = 2'b00,
		PBC_SPD_100 = 2'b01,
		PBC_SPD_1000 = 2'b10,
		PBC_SPD_NONE = 2'b11
	} pbc_speed_t;

	// Next-page exchange states
	typedef enum logic [2:0] {
		PBC_NP_IDLE = 3'b000,
		PBC_NP_BASE = 3'b001,
		PBC_NP_AUTO = 3'b010,
		PBC_NP_USER = 3'b011,
		PBC_NP_DONE = 3'b100
	} pbc_np_state_t;

	// Controls driven into the PCS and auto-negotiation logic
	typedef struct packed {
		logic coder_bypass;
		logic scr_bypass;
		logic descr_bypass;
		logic no_pair_swap;
		logic no_pol_fix;
		logic use_adv_in_pd;
	} pbc_ctrl_t;

endpackage : pbc_pkg

/* core/pbc_sync2.sv */
// Two-flop synchroniser for pin-level inputs
module pbc_sync2
	import pbc_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	// Elaboration check; a zero-width synchroniser has nothing to carry
	if (WIDTH < 1)
	begin : g_bad_width
		$error("pbc_sync2: WIDTH must be at least 1");
	end

	// First stage feeds only the second
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end

endmodule : pbc_sync2

/* core/pbc_clk_out.sv */
// Clock output gate for the MAC reference and general clock pins
module pbc_clk_out
	import pbc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic hw_rst_n,
	input wire logic mac_en,
	input wire logic test_sel,
	input wire logic test_clk,
	input wire logic gen_clk,
	output logic mac_ref_clock_pin,
	output logic general_clock_out_pin
);

	// PLL is off while hardware reset is low, so the pin is held low then
	assign mac_ref_clock_pin = hw_rst_n & mac_en & ref_clk;
	// Test clock takes the general pin only for jitter measurement
	assign general_clock_out_pin = test_sel ? test_clk : gen_clk;

endmodule : pbc_clk_out

/* verif/phy_bypass_control_regs_tb.sv */
// Self-checking bench for the bypass control register bank
`include "pbc_defines.svh"
module phy_bypass_control_regs_tb
	import pbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, hw_rst_n = 1, sw_rst = 0, sticky_en = 0;
	pbc_mgmt_req_t req = '0;
	logic [15:0] rdata, v, d;
	logic rvalid, delim = 0, fv = 0, crs, adv = 0, sw_c, auto_a, ttc = 0, gclk = 0, mac_pin, gen_pin;
	logic [3:0] ev = '0;
	logic [4:0] raw = 0, coded = 0, al = 0, dec = 0, tx_o, rx_o;
	pbc_speed_t speed = PBC_SPD_100;
	pbc_ctrl_t ctrl;
	int fail_count = 0, tests_run = 0, cyc = 0;

	pbc_bypass_regs DUT (
		.ref_clk(ref_clk), .rst(rst), .hw_rst_n(hw_rst_n), .sw_rst(sw_rst), .sticky_en(sticky_en),
		.mgmt_req(req), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .speed(speed),
		.tx_sym_raw(raw), .tx_sym_coded(coded), .tx_coded_delim(delim), .tx_sym_to_scr(tx_o),
		.rx_sym_aligned(al), .rx_sym_decoded(dec), .rx_sym_out(rx_o), .rx_frame_valid(fv), .crs(crs),
		.ctrl(ctrl), .an_start(ev[0]), .adv_np(adv), .base_page_done(ev[1]), .auto_np_done(ev[2]),
		.an_end(ev[3]), .np_sw_control(sw_c), .np_auto_active(auto_a), .transmit_test_clock(ttc),
		.gen_clk(gclk), .mac_ref_clock_pin(mac_pin), .general_clock_out_pin(gen_pin)
	);

	// Free-running 125 MHz clock
	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end

	// Controls expected from a register value at a given speed
	function automatic pbc_ctrl_t exp_ctrl(logic [15:0] r, pbc_speed_t s);
		logic sp;
		sp = (s == PBC_SPD_100) || (s == PBC_SPD_1000);
		return '{r[14] && s == PBC_SPD_100, r[13] && sp, r[12] && sp, r[5], r[4], r[3]};
	endfunction : exp_ctrl

	task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	task automatic wr(logic [4:0] a, logic [15:0] w);
		@(posedge ref_clk);
		#1 req = '{1'b1, 1'b0, a, w};
		@(posedge ref_clk);
		#1 req.wr = 0;
	endtask : wr

	// Read data is valid for one cycle only, so it is taken right after the edge
	task automatic rd(logic [4:0] a, output logic [15:0] r);
		@(posedge ref_clk);
		#1 req = '{1'b0, 1'b1, a, 16'h0000};
		@(posedge ref_clk);
		#1 req.rd = 0;
		r = rdata;
		chk("rvalid", rvalid, 1);
	endtask : rd

	task automatic pulse(int k);
		@(posedge ref_clk);
		#1 ev[k] = 1;
		@(posedge ref_clk);
		#1 ev = '0;
	endtask : pulse

	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			report_and_stop();
		end
	end

	// Main sequence: reset values, reserved places, random traffic, sticky reset, next pages, clock gate
	initial
	begin
		void'($urandom(32'h720e));
		repeat (10) @(posedge ref_clk);
		#1 rst = 0;
		rd(`PBC_OFS_BYPASS, d);
		chk("reset_val", d, 16'h0009);
		repeat (2) @(posedge ref_clk);
		#1 chk("reset_ctrl", ctrl, exp_ctrl(16'h0009, speed));
		for (int i = 0; i < 3; i++)
		begin
			v = i == 0 ? `PBC_OFS_RSVD_A : i == 1 ? `PBC_OFS_RSVD_B : `PBC_OFS_RSVD_C;
			wr(v[4:0], 16'hffff);
			rd(v[4:0], d);
			chk("rsvd", d, 16'h0000);
		end
		for (int i = 0; i < 40; i++)
		begin
			v = i == 0 ? 16'hffff : $urandom;
			speed = pbc_speed_t'($urandom_range(3, 0));
			wr(`PBC_OFS_BYPASS, v);
			rd(`PBC_OFS_BYPASS, d);
			v = v & `PBC_WR_MASK;
			chk("readback", d, v);
			{raw, coded, al, dec, fv, ttc, gclk, delim} = $urandom;
			repeat (3) @(posedge ref_clk);
			#1 chk("ctrl", ctrl, exp_ctrl(v, speed));
			chk("tx_sym", tx_o, (v[14] && speed == PBC_SPD_100) ? raw : coded);
			chk("rx_sym", rx_o, (v[14] && speed == PBC_SPD_100) ? al : dec);
			chk("crs", crs, fv);
			chk("gen_pin", gen_pin, v[8] ? ttc : gclk);
			chk("mac_high", mac_pin, v[0]);
			#4 chk("mac_low", mac_pin, 0);
		end
		// Sticky bits with and without the enable
		for (int s = 0; s < 2; s++)
		begin
			wr(`PBC_OFS_BYPASS, 16'hffff);
			@(posedge ref_clk);
			#1 sw_rst = 1;
			sticky_en = s[0];
			@(posedge ref_clk);
			#1 sw_rst = 0;
			rd(`PBC_OFS_BYPASS, d);
			chk("sticky", d, s ? (`PBC_WR_MASK & `PBC_STICKY_MASK) : `PBC_RESET_VAL);
		end
		// Next-page hand-over for every combination of disable bit and advertised next page
		for (int k = 0; k < 4; k++)
		begin
			wr(`PBC_OFS_BYPASS, {14'h0000, k[0], 1'b1});
			adv = k[1];
			pulse(0);
			chk("np_base_sw", sw_c, 0);
			pulse(1);
			chk("np_sw", sw_c, k[0]);
			chk("np_auto", auto_a, !k[0]);
			if (!k[0])
			begin
				pulse(2);
				chk("np_done_sw", sw_c, k[1]);
				chk("np_done_auto", auto_a, 0);
			end
			pulse(3);
		end
		// Hardware reset stops the MAC clock even while enabled; the pin is retimed first
		wr(`PBC_OFS_BYPASS, 16'h0001);
		@(posedge ref_clk);
		#1 hw_rst_n = 0;
		repeat (3) @(posedge ref_clk);
		#1 chk("mac_hwrst", mac_pin, 0);
		hw_rst_n = 1;
		repeat (3) @(posedge ref_clk);
		#1 chk("mac_back", mac_pin, 1);
		// Mid-run reset brings back the reset value and the steering
		wr(`PBC_OFS_BYPASS, 16'hffff);
		@(posedge ref_clk);
		#1 rst = 1;
		repeat (2) @(posedge ref_clk);
		#1 rst = 0;
		rd(`PBC_OFS_BYPASS, d);
		chk("rerst_val", d, `PBC_RESET_VAL);
		chk("rerst_ctrl", ctrl, exp_ctrl(`PBC_RESET_VAL, speed));
		report_and_stop();
	end

endmodule : phy_bypass_control_regs_tb
